// ### hw/wdt_div.v
`timescale 1ns/1ns
`include "wdt_defs.vh"

module wdt_div (
    input wire clk_in,
    input wire rst_n_in,
    input wire clear_in,
    input wire tick_in,
    input wire ratio_sel_in,
    input wire [`WDT_POST_SEL_W-1:0] post_sel_in,
    output wire timeout_out,
    output wire [`WDT_POST_W-1:0] post_count_out
);

    // Terminal count of the postscaler for a ratio of 2 to the n
    function [`WDT_POST_W-1:0] post_last;
        input [`WDT_POST_SEL_W-1:0] sel;
        begin
            post_last = ({`WDT_POST_W{1'b1}} >> (4'hF - sel));
        end
    endfunction

    reg [`WDT_PRE_W-1:0] pre_q;
    reg [`WDT_POST_W-1:0] post_q;
    wire [`WDT_PRE_W-1:0] pre_last;
    wire pre_carry;

    assign pre_last = ratio_sel_in ? `WDT_PRE_LONG_LAST : `WDT_PRE_SHORT_LAST;
    assign pre_carry = tick_in && (pre_q >= pre_last);
    assign timeout_out = pre_carry && (post_q >= post_last(post_sel_in));
    assign post_count_out = post_q;

    always @(posedge clk_in) begin
        if (!rst_n_in || clear_in) begin
            pre_q <= {`WDT_PRE_W{1'b0}};
            post_q <= {`WDT_POST_W{1'b0}};
        end else if (tick_in) begin
            if (pre_carry) begin
                pre_q <= {`WDT_PRE_W{1'b0}};
                if (timeout_out) begin
                    post_q <= {`WDT_POST_W{1'b0}};
                end else begin
                    post_q <= post_q + 1'b1;
                end
            end else begin
                pre_q <= pre_q + 1'b1;
            end
        end
    end

endmodule

// ### hw/wdt_top.v
`timescale 1ns/1ns
`include "wdt_defs.vh"

// Summary of operation
// - Counts the low-power RC clock; enabling the watchdog enables that oscillator.
// - Prescaler divides the RC clock by 32 or by 128.
// - Prescaler output gives 1 ms or 4 ms base period at 32 kHz.
// - Four-bit postscaler divides the base further, sixteen settings.
// - Postscaler code n divides by two to the n.
// - Prescale select one gives 128, zero gives 32.
// - Device reset and clock switch completion clear all counters.
// - Entering and leaving sleep or idle clears all counters.
// - Clear instruction in normal execution clears all counters.
// - Enabled watchdog keeps counting in sleep and idle.
// - Time-out in sleep or idle wakes the core, no reset.
// - Every time-out sets a sticky flag cleared only by software or the reset input.
// - Fuse enable set keeps the watchdog always running.
// - Fuse enable clear makes the software enable bit control running.
// - Software enable bit clears on any device reset.
module wdt_top (
    input wire CLOCK_IN,
    input wire RST_N_IN,
    input wire LOW_POWER_RC_OSC_CLK_IN,
    input wire WATCHDOG_FUSE_ENABLE_IN,
    input wire PRESCALE_RATIO_SELECT_IN,
    input wire [`WDT_POST_SEL_W-1:0] POSTSCALE_SELECT_IN,
    input wire CLOCK_SWITCH_DONE_IN,
    input wire POWER_SAVE_INSTR_IN,
    input wire POWER_SAVE_IDLE_IN,
    input wire WAKE_EVENT_IN,
    input wire WATCHDOG_CLEAR_INSTR_IN,
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [`WDT_ADDR_W-1:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    output wire PREADY_OUT,
    output wire PSLVERR_OUT,
    output wire [31:0] PRDATA_OUT,
    output wire LOW_POWER_RC_OSC_EN_OUT,
    output wire WAKE_OUT,
    output wire WDT_RESET_OUT,
    output wire IRQ_OUT
);

    // ----------------------------------------------------------------
    // Power states
    // ----------------------------------------------------------------
    localparam ST_RUN = 2'b00;
    localparam ST_SLEEP = 2'b01;
    localparam ST_IDLE = 2'b10;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg soft_en_q;
    reg soft_en_d;
    reg timeout_flag_q;
    reg timeout_flag_d;
    reg sleep_flag_q;
    reg sleep_flag_d;
    reg idle_flag_q;
    reg idle_flag_d;
    reg [`WDT_IRQ_W-1:0] irq_status_q;
    reg [`WDT_IRQ_W-1:0] irq_status_d;
    reg [`WDT_IRQ_W-1:0] irq_enable_q;
    reg [`WDT_IRQ_W-1:0] irq_enable_d;
    reg rc_osc_prev_q;
    reg wake_q;
    reg wdt_reset_q;
    reg [31:0] prdata_q;
    reg [31:0] prdata_d;
    reg slverr_q;
    reg slverr_d;

    wire running;
    wire rc_osc_rise;
    wire count_tick;
    wire div_timeout;
    wire div_clear;
    wire [`WDT_POST_W-1:0] post_count;
    wire in_power_save;
    wire enter_power_save;
    wire leave_power_save;
    wire normal_clear;
    wire timeout_normal;
    wire timeout_saved;
    wire apb_setup;
    wire apb_access;
    wire apb_write;
    wire apb_read;
    wire addr_ok;
    wire [`WDT_IRQ_W-1:0] irq_events;
    wire wr_reset_ctrl;
    wire wr_irq_enable;
    wire wr_irq_clear;
    wire osc_enable;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function is_mapped;
        input [`WDT_ADDR_W-1:0] addr;
        begin
            if (addr == `WDT_OFS_RESET_CTRL) begin
                is_mapped = 1'b1;
            end else if (addr == `WDT_OFS_STATUS) begin
                is_mapped = 1'b1;
            end else if (addr == `WDT_OFS_IRQ_STATUS) begin
                is_mapped = 1'b1;
            end else if (addr == `WDT_OFS_IRQ_ENABLE) begin
                is_mapped = 1'b1;
            end else if (addr == `WDT_OFS_IRQ_CLEAR) begin
                is_mapped = 1'b1;
            end else begin
                is_mapped = 1'b0;
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Enable and clock source
    // ----------------------------------------------------------------
    // fuse forces running
    assign running = WATCHDOG_FUSE_ENABLE_IN || soft_en_q;

    assign osc_enable = running;
    assign LOW_POWER_RC_OSC_EN_OUT = osc_enable;

    // RC clock is slow against the core clock, so one edge per tick
    assign rc_osc_rise = LOW_POWER_RC_OSC_CLK_IN && !rc_osc_prev_q;

    // power state does not gate
    // Counts are in RC ticks, so the core clock rate does not matter
    assign count_tick = rc_osc_rise && running;

    // ----------------------------------------------------------------
    // Sequencing events
    // ----------------------------------------------------------------
    assign in_power_save = (state_q != ST_RUN);
    // A time-out in the same cycle wins: the reset request, not sleep
    assign enter_power_save = POWER_SAVE_INSTR_IN && !in_power_save && !div_timeout;
    assign timeout_normal = div_timeout && !in_power_save;
    assign timeout_saved = div_timeout && in_power_save;
    assign leave_power_save = in_power_save && (WAKE_EVENT_IN || timeout_saved);
    assign normal_clear = WATCHDOG_CLEAR_INSTR_IN && !in_power_save;

    // clock switch, power-save entry or exit, clear instruction, time-out
    // Held clear while stopped, so a restart begins a full period
    assign div_clear = CLOCK_SWITCH_DONE_IN || enter_power_save || leave_power_save ||
                       normal_clear || timeout_normal || !running;

    wdt_div i_wdt_div (
        .clk_in(CLOCK_IN),
        .rst_n_in(RST_N_IN),
        .clear_in(div_clear),
        .tick_in(count_tick),
        .ratio_sel_in(PRESCALE_RATIO_SELECT_IN),
        .post_sel_in(POSTSCALE_SELECT_IN),
        .timeout_out(div_timeout),
        .post_count_out(post_count)
    );

    // ----------------------------------------------------------------
    // Power state machine
    // ----------------------------------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (enter_power_save) begin
                    state_d = POWER_SAVE_IDLE_IN ? ST_IDLE : ST_SLEEP;
                end
            end
            ST_SLEEP, ST_IDLE: begin
                if (leave_power_save) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // Zero wait states; the answer is ready in the access cycle
    assign apb_setup = PSEL_IN && !PENABLE_IN;
    assign apb_access = PSEL_IN && PENABLE_IN;
    assign apb_write = apb_access && PWRITE_IN && addr_ok;
    assign apb_read = apb_setup && !PWRITE_IN;
    assign addr_ok = is_mapped(PADDR_IN);
    assign PREADY_OUT = apb_access;
    assign PSLVERR_OUT = apb_access && slverr_q;
    assign PRDATA_OUT = prdata_q;

    // ----------------------------------------------------------------
    // Register write strobes
    // ----------------------------------------------------------------
    // Decoded once so every writer sees the same address match
    assign wr_reset_ctrl = apb_write && (PADDR_IN == `WDT_OFS_RESET_CTRL);
    assign wr_irq_enable = apb_write && (PADDR_IN == `WDT_OFS_IRQ_ENABLE);
    assign wr_irq_clear = apb_write && (PADDR_IN == `WDT_OFS_IRQ_CLEAR);

    // Read data captured in setup so it stands through the access phase
    always @* begin
        prdata_d = prdata_q;
        slverr_d = slverr_q;
        if (apb_setup) begin
            slverr_d = !is_mapped(PADDR_IN);
            prdata_d = 32'h00000000;
            if (apb_read) begin
                if (PADDR_IN == `WDT_OFS_RESET_CTRL) begin
                    prdata_d[`WDT_RC_SOFT_EN_BIT] = soft_en_q;
                    prdata_d[`WDT_RC_TIMEOUT_BIT] = timeout_flag_q;
                    prdata_d[`WDT_RC_SLEEP_BIT] = sleep_flag_q;
                    prdata_d[`WDT_RC_IDLE_BIT] = idle_flag_q;
                end else if (PADDR_IN == `WDT_OFS_STATUS) begin
                    prdata_d[`WDT_ST_RUNNING_BIT] = running;
                    prdata_d[`WDT_ST_OSC_EN_BIT] = osc_enable;
                    prdata_d[`WDT_ST_STATE_LSB +: 2] = state_q;
                    prdata_d[`WDT_ST_POST_LSB +: `WDT_POST_W] = post_count;
                end else if (PADDR_IN == `WDT_OFS_IRQ_STATUS) begin
                    prdata_d[`WDT_IRQ_W-1:0] = irq_status_q;
                end else if (PADDR_IN == `WDT_OFS_IRQ_ENABLE) begin
                    prdata_d[`WDT_IRQ_W-1:0] = irq_enable_q;
                end else begin
                    prdata_d = 32'h00000000;
                end
            end
        end
    end

    // Bus flops kept apart from the watchdog state
    always @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            prdata_q <= 32'h00000000;
            slverr_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            slverr_q <= slverr_d;
        end
    end

    // ----------------------------------------------------------------
    // Reset-control register
    // ----------------------------------------------------------------
    always @* begin
        soft_en_d = soft_en_q;
        timeout_flag_d = timeout_flag_q;
        sleep_flag_d = sleep_flag_q;
        idle_flag_d = idle_flag_q;
        if (wr_reset_ctrl) begin
            soft_en_d = PWDATA_IN[`WDT_RC_SOFT_EN_BIT];
            timeout_flag_d = timeout_flag_q && PWDATA_IN[`WDT_RC_TIMEOUT_BIT];
            sleep_flag_d = sleep_flag_q && PWDATA_IN[`WDT_RC_SLEEP_BIT];
            idle_flag_d = idle_flag_q && PWDATA_IN[`WDT_RC_IDLE_BIT];
        end
        // Hardware sets win over a clearing write in the same cycle
        if (enter_power_save) begin
            sleep_flag_d = sleep_flag_d || !POWER_SAVE_IDLE_IN;
            idle_flag_d = idle_flag_d || POWER_SAVE_IDLE_IN;
        end
        if (div_timeout) begin
            timeout_flag_d = 1'b1;
        end
        // watchdog reset is a device reset
        if (timeout_normal) begin
            soft_en_d = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status, enable and clear
    // ----------------------------------------------------------------
    // Bit 1 also rises on a wake from another source
    assign irq_events = {leave_power_save, div_timeout};

    always @* begin
        irq_status_d = irq_status_q;
        irq_enable_d = irq_enable_q;
        if (wr_irq_clear) begin
            irq_status_d = irq_status_q & ~PWDATA_IN[`WDT_IRQ_W-1:0];
        end
        if (wr_irq_enable) begin
            irq_enable_d = PWDATA_IN[`WDT_IRQ_W-1:0];
        end
        irq_status_d = irq_status_d | irq_events;
    end

    assign IRQ_OUT = |(irq_status_q & irq_enable_q);

    // ----------------------------------------------------------------
    // Flip-flops
    // ----------------------------------------------------------------
    always @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            state_q <= ST_RUN;
            soft_en_q <= 1'b0;
            timeout_flag_q <= 1'b0;
            sleep_flag_q <= 1'b0;
            idle_flag_q <= 1'b0;
            irq_status_q <= {`WDT_IRQ_W{1'b0}};
            irq_enable_q <= {`WDT_IRQ_W{1'b0}};
            rc_osc_prev_q <= 1'b0;
            wake_q <= 1'b0;
            wdt_reset_q <= 1'b0;
        end else begin
            state_q <= state_d;
            soft_en_q <= soft_en_d;
            timeout_flag_q <= timeout_flag_d;
            sleep_flag_q <= sleep_flag_d;
            idle_flag_q <= idle_flag_d;
            irq_status_q <= irq_status_d;
            irq_enable_q <= irq_enable_d;
            rc_osc_prev_q <= LOW_POWER_RC_OSC_CLK_IN;
            wake_q <= leave_power_save;
            wdt_reset_q <= timeout_normal;
        end
    end

    assign WAKE_OUT = wake_q;
    assign WDT_RESET_OUT = wdt_reset_q;

endmodule

// ### shared/wdt_defs.vh
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH

// ----------------------------------------------------------------
// Watchdog clock and timing
// ----------------------------------------------------------------
`define WDT_CLOCK_HZ 25000000
`define WDT_RC_OSC_HZ 32000
`define WDT_BASE_SHORT_US 1000
`define WDT_BASE_LONG_US 4000
`define WDT_PRE_SHORT_DIV (`WDT_RC_OSC_HZ * `WDT_BASE_SHORT_US / 1000000)
`define WDT_PRE_LONG_DIV (`WDT_RC_OSC_HZ * `WDT_BASE_LONG_US / 1000000)
// Terminal counts, one below the two divide ratios
`define WDT_PRE_SHORT_LAST 7'h1F
`define WDT_PRE_LONG_LAST 7'h7F
`define WDT_PRE_W 7
`define WDT_POST_W 15
`define WDT_POST_SEL_W 4

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define WDT_ADDR_W 12
`define WDT_OFS_RESET_CTRL 12'h000
`define WDT_OFS_STATUS 12'h004
`define WDT_OFS_IRQ_STATUS 12'h008
`define WDT_OFS_IRQ_ENABLE 12'h00C
`define WDT_OFS_IRQ_CLEAR 12'h010

// ----------------------------------------------------------------
// Reset-control register fields
// ----------------------------------------------------------------
`define WDT_RC_SOFT_EN_BIT 5
`define WDT_RC_TIMEOUT_BIT 4
`define WDT_RC_SLEEP_BIT 3
`define WDT_RC_IDLE_BIT 2

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define WDT_ST_RUNNING_BIT 0
`define WDT_ST_OSC_EN_BIT 1
`define WDT_ST_STATE_LSB 2
`define WDT_ST_POST_LSB 16

// ----------------------------------------------------------------
// Interrupt event bits
// ----------------------------------------------------------------
`define WDT_IRQ_W 2
`define WDT_IRQ_TIMEOUT_BIT 0
`define WDT_IRQ_WAKE_BIT 1

`endif

// ### testbench/wdt_monitor.sv
`timescale 1ns/1ns
`include "wdt_defs.vh"

module wdt_monitor (
    input wire CLOCK_IN,
    input wire RST_N_IN,
    input wire WATCHDOG_FUSE_ENABLE_IN,
    input wire WATCHDOG_CLEAR_INSTR_IN,
    input wire CLOCK_SWITCH_DONE_IN,
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PREADY_OUT,
    input wire PSLVERR_OUT,
    input wire LOW_POWER_RC_OSC_EN_OUT,
    input wire WAKE_OUT,
    input wire WDT_RESET_OUT,
    input wire IRQ_OUT
);
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_N_IN);

    // ------------------------------------------------
    // Bus
    // ------------------------------------------------
    a_ready_access: assert property (PREADY_OUT == (PSEL_IN && PENABLE_IN))
        else $error("pready outside access phase");
    a_err_access: assert property (PSLVERR_OUT |-> PSEL_IN && PENABLE_IN)
        else $error("pslverr outside access phase");

    // ------------------------------------------------
    // Watchdog
    // ------------------------------------------------
    a_osc_fuse_on: assert property (WATCHDOG_FUSE_ENABLE_IN |-> LOW_POWER_RC_OSC_EN_OUT)
        else $error("fuse set but oscillator off");
    a_stopped_no_reset: assert property (
        !LOW_POWER_RC_OSC_EN_OUT && $past(!LOW_POWER_RC_OSC_EN_OUT) |-> !WDT_RESET_OUT)
        else $error("time-out while stopped");
    a_soft_en_reset: assert property (disable iff (1'b0)
        !RST_N_IN ##1 !WATCHDOG_FUSE_ENABLE_IN |-> !LOW_POWER_RC_OSC_EN_OUT)
        else $error("soft enable survives reset");
    a_reset_one_cycle: assert property (WDT_RESET_OUT |=> !WDT_RESET_OUT)
        else $error("reset request longer than one cycle");
    a_wake_one_cycle: assert property (WAKE_OUT |=> !WAKE_OUT)
        else $error("wake longer than one cycle");
    a_wake_not_reset: assert property (!(WAKE_OUT && WDT_RESET_OUT))
        else $error("wake and reset together");
    a_clear_restarts: assert property (WATCHDOG_CLEAR_INSTR_IN |-> ##2 !WDT_RESET_OUT)
        else $error("time-out right after clear");
    a_switch_restarts: assert property (
        CLOCK_SWITCH_DONE_IN |-> ##2 (!WDT_RESET_OUT) [*3])
        else $error("time-out right after clock switch");
    a_quiet_in_reset: assert property (disable iff (1'b0)
        !RST_N_IN |=> !WDT_RESET_OUT && !WAKE_OUT && !IRQ_OUT)
        else $error("events during reset");

    c_reset: cover property (WDT_RESET_OUT);
    c_wake: cover property (WAKE_OUT);
    c_irq: cover property (IRQ_OUT);
    c_err: cover property (PSLVERR_OUT);
endmodule

bind wdt_top wdt_monitor i_wdt_monitor (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
    .WATCHDOG_FUSE_ENABLE_IN(WATCHDOG_FUSE_ENABLE_IN),
    .WATCHDOG_CLEAR_INSTR_IN(WATCHDOG_CLEAR_INSTR_IN),
    .CLOCK_SWITCH_DONE_IN(CLOCK_SWITCH_DONE_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .LOW_POWER_RC_OSC_EN_OUT(LOW_POWER_RC_OSC_EN_OUT),
    .WAKE_OUT(WAKE_OUT), .WDT_RESET_OUT(WDT_RESET_OUT), .IRQ_OUT(IRQ_OUT));

// ### testbench/wdt_top_tb.sv
`timescale 1ns/1ns
`include "wdt_defs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("wrong value at %0t: got %0h want %0h", $time, g, e); end end

module wdt_top_tb;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg rc_clk = 1'b0;
    reg fuse = 1'b0;
    reg ratio = 1'b0;
    reg [3:0] post = 4'h0;
    reg csw = 1'b0;
    reg psv = 1'b0;
    reg idle = 1'b0;
    reg wev = 1'b0;
    reg clr = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    wire pready, pslverr, osc_en, wake, wdt_rst, irq;
    wire [31:0] prdata;
    reg [31:0] rd;
    reg er;
    int failures = 0;
    int checked = 0;
    int rst_cnt = 0;
    int wake_cnt = 0;

    wdt_top i_wdt_top (.CLOCK_IN(clk), .RST_N_IN(rst_n), .LOW_POWER_RC_OSC_CLK_IN(rc_clk),
        .WATCHDOG_FUSE_ENABLE_IN(fuse), .PRESCALE_RATIO_SELECT_IN(ratio),
        .POSTSCALE_SELECT_IN(post), .CLOCK_SWITCH_DONE_IN(csw), .POWER_SAVE_INSTR_IN(psv),
        .POWER_SAVE_IDLE_IN(idle), .WAKE_EVENT_IN(wev), .WATCHDOG_CLEAR_INSTR_IN(clr),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PRDATA_OUT(prdata),
        .LOW_POWER_RC_OSC_EN_OUT(osc_en), .WAKE_OUT(wake), .WDT_RESET_OUT(wdt_rst),
        .IRQ_OUT(irq));

    always #20 clk = ~clk;

    always @(posedge clk) begin
        if (wdt_rst === 1'b1) rst_cnt++;
        if (wake === 1'b1) wake_cnt++;
    end

    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge so what the access edge launched has settled
        @(posedge clk);
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    task pulse(input int s);
        @(posedge clk);
        case (s)
            0: clr <= 1'b1;
            1: csw <= 1'b1;
            2: psv <= 1'b1;
            default: wev <= 1'b1;
        endcase
        @(posedge clk);
        {clr, csw, psv, wev} <= 4'h0;
    endtask

    // Four core cycles per tick, far slower than the edge detector needs
    task ticks(input int n);
        repeat (n) begin
            @(posedge clk) rc_clk <= 1'b1;
            @(posedge clk);
            @(posedge clk) rc_clk <= 1'b0;
            @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask

    task tmo(input int n, input logic wk);
        int r0, w0;
        r0 = rst_cnt;
        w0 = wake_cnt;
        ticks(n - 1);
        `CHK(rst_cnt + wake_cnt, r0 + w0)
        ticks(1);
        `CHK(wk ? wake_cnt - w0 : rst_cnt - r0, 1)
        `CHK(wk ? rst_cnt - r0 : wake_cnt - w0, 0)
    endtask

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task t_soft_enable;
        int r0;
        `CHK(osc_en, 1'b0)
        rdchk(`WDT_OFS_RESET_CTRL, 32'h0);
        r0 = rst_cnt;
        ticks(40);
        `CHK(rst_cnt, r0)
        apb(1'b1, `WDT_OFS_RESET_CTRL, 32'h3C);
        `CHK(osc_en, 1'b1)
        tmo(32, 1'b0);
        rdchk(`WDT_OFS_RESET_CTRL, 32'h10);
        $display("done soft enable");
    endtask

    task t_sticky_irq;
        fuse <= 1'b1;
        apb(1'b1, `WDT_OFS_IRQ_ENABLE, 32'h1);
        `CHK(irq, 1'b1)
        rdchk(`WDT_OFS_IRQ_STATUS, 32'h1);
        apb(1'b1, `WDT_OFS_IRQ_CLEAR, 32'h1);
        `CHK(irq, 1'b0)
        rdchk(`WDT_OFS_RESET_CTRL, 32'h10);
        apb(1'b1, `WDT_OFS_RESET_CTRL, 32'h0);
        rdchk(`WDT_OFS_RESET_CTRL, 32'h0);
        $display("done sticky flag");
    endtask

    task t_ratios;
        logic [5:0] cfg [4] = '{6'h00, 6'h02, 6'h20, 6'h21};
        for (int i = 0; i < 4; i++) begin
            ratio <= cfg[i][5];
            post <= cfg[i][3:0];
            pulse(0);
            tmo((cfg[i][5] ? 128 : 32) << cfg[i][3:0], 1'b0);
        end
        $display("done ratios");
    endtask

    task t_restarts;
        ratio <= 1'b0;
        post <= 4'h0;
        pulse(0);
        ticks(20);
        pulse(0);
        tmo(32, 1'b0);
        ticks(20);
        pulse(1);
        tmo(32, 1'b0);
        $display("done restarts");
    endtask

    task t_power_save;
        apb(1'b1, `WDT_OFS_RESET_CTRL, 32'h0);
        ticks(20);
        idle <= 1'b0;
        pulse(2);
        tmo(32, 1'b1);
        rdchk(`WDT_OFS_RESET_CTRL, 32'h18);
        apb(1'b1, `WDT_OFS_RESET_CTRL, 32'h0);
        ticks(20);
        idle <= 1'b1;
        pulse(2);
        ticks(20);
        rdchk(`WDT_OFS_STATUS, 32'hB);
        pulse(3);
        repeat (4) @(posedge clk);
        `CHK(wake_cnt, 2)
        tmo(32, 1'b0);
        rdchk(`WDT_OFS_RESET_CTRL, 32'h14);
        rdchk(`WDT_OFS_IRQ_STATUS, 32'h3);
        $display("done power save");
    endtask

    task t_bus_errors;
        rdchk(12'h020, 32'h0);
        `CHK(er, 1'b1)
        apb(1'b1, `WDT_OFS_IRQ_STATUS, 32'h3);
        `CHK(er, 1'b0)
        $display("done bus errors");
    endtask

    task end_sim;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #800000;
        failures++;
        end_sim;
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_soft_enable;
        t_sticky_irq;
        t_ratios;
        t_restarts;
        t_power_save;
        t_bus_errors;
        end_sim;
    end
endmodule
